// *** rtl/nvm_ctrl.sv ***
// NVM program/erase controller with Avalon-MM register slave
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] EEPROM space: erase then write, erase-select ignored
// [R2] Start write sets error flag; clean finish clears
// [R3] Enable bit low blocks all program/erase
// [R4] Start launches timed op, hardware clears it
// [R5] Software can only set program start
// [R6] Read start fetches word in one cycle
// [R7] Software can only set read start
// [R8] Software writes 55h then AAh first
// [R9] Unlock port write-only, pattern only
// [R10] Address high bit 7 reads one
// [R11] Data high bits 7:6 read zero
// [R12] Low address and data fully read/write
// [R13] Flash select one flash, zero EEPROM
// [R14] Bad config read clears data registers
// [R15] Latch-only bit: update latches, no program
// [R16] Erase-select erases; cleared after erase
// [R17] No unlock or disabled: array unchanged
// [R18] Busy ignores further start and read
module nvm_ctrl #(
  parameter int PROG_CYCLES = nvm_ctrl_pkg::PROG_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic IRQ_O
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } op_state_t;

  localparam int CW = $clog2(PROG_CYCLES + 1);

  op_state_t state_q;
  logic [CW-1:0] count_q;
  logic [7:0] control_q;
  logic [7:0] addr_lo_q;
  logic [6:0] addr_hi_q;
  logic [7:0] data_lo_q;
  logic [5:0] data_hi_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic irq_q;
  logic op_erase_q;
  logic op_commit_q;

  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic busy;
  logic armed;
  logic start_req;
  logic start_ok;
  logic read_req;
  logic latch_pulse;
  logic commit_pulse;
  logic finish;
  logic abort;
  logic [14:0] full_addr;
  logic [13:0] arr_rdata;
  logic arr_rvalid;
  logic ee_space;
  logic [1:0] irq_event;
  logic irq_clear_wr;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================================
  // Bus slave: one wait cycle, then answer on the edge waitrequest is low
  assign wr_acc = AVS_WRITE_I && !wait_q;
  assign rd_acc = AVS_READ_I && !wait_q;
  assign wbyte = AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[7:0] : 8'h00;

  // Idle level is high, so every request sees exactly one wait cycle
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      wait_q <= 1'b1;
    end else if ((AVS_READ_I || AVS_WRITE_I) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Captured when the request is first seen; stands until the next access
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rdata_q <= 32'h0000_0000;
    end else if ((AVS_READ_I || AVS_WRITE_I) && wait_q) begin
      case (AVS_ADDRESS_I)
        nvm_ctrl_pkg::OFS_CONTROL: rdata_q <= {24'h000000, control_q};
        nvm_ctrl_pkg::OFS_UNLOCK: rdata_q <= 32'h0000_0000; // [R9]
        nvm_ctrl_pkg::OFS_ADDR_LO: rdata_q <= {24'h000000, addr_lo_q}; // [R12]
        nvm_ctrl_pkg::OFS_ADDR_HI: rdata_q <= {24'h000000, 1'b1, addr_hi_q}; // [R10]
        nvm_ctrl_pkg::OFS_DATA_LO: rdata_q <= {24'h000000, data_lo_q}; // [R12]
        nvm_ctrl_pkg::OFS_DATA_HI: rdata_q <= {24'h000000, 2'b00, data_hi_q}; // [R11]
        nvm_ctrl_pkg::OFS_IRQ_STATUS: rdata_q <= {30'h0000_0000, irq_stat_q};
        nvm_ctrl_pkg::OFS_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Unlock recogniser
  // Progress is dropped by any other register write
  nvm_unlock u_unlock (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .wr_i(wr_acc && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_UNLOCK)), // [R9]
    .data_i(wbyte),
    .consume_i(start_req),
    .other_wr_i(wr_acc && !hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_UNLOCK)),
    .armed_o(armed)
  );

  // ==========================================================================
  // Start decode
  assign busy = (state_q != ST_IDLE);
  assign start_req = wr_acc && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_CONTROL) &&
    wbyte[nvm_ctrl_pkg::BIT_PROG_START] && !busy; // [R18]
  // Unlock must precede the start, and the enable bit must already be set
  assign start_ok = start_req && armed && control_q[nvm_ctrl_pkg::BIT_PROG_EN]; // [R3] [R8] [R17]
  assign read_req = wr_acc && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_CONTROL) &&
    wbyte[nvm_ctrl_pkg::BIT_READ_START] && !busy; // [R18]
  assign ee_space = !control_q[nvm_ctrl_pkg::BIT_CFG_SEL] &&
    !control_q[nvm_ctrl_pkg::BIT_FLASH_SEL];
  assign full_addr = {addr_hi_q, addr_lo_q};
  // A refused start still raises the error flag and the abort event
  assign abort = start_req && !start_ok;

  // ==========================================================================
  // Self-timed sequencer
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      count_q <= '0;
      op_erase_q <= 1'b0;
      op_commit_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_BUSY; // [R4]
            // Busy for PROG_CYCLES edges, then one done cycle
            count_q <= CW'(PROG_CYCLES - 1);
            // EEPROM ignores erase-select: the commit does erase then write
            op_erase_q <= ee_space ? 1'b0 : control_q[nvm_ctrl_pkg::BIT_ERASE_SEL]; // [R1] [R16]
            op_commit_q <= ee_space || control_q[nvm_ctrl_pkg::BIT_ERASE_SEL] ||
              !control_q[nvm_ctrl_pkg::BIT_LATCH_ONLY]; // [R15]
          end
        end
        ST_BUSY: begin
          if (count_q == '0) begin
            state_q <= ST_DONE;
          end else begin
            count_q <= count_q - CW'(1);
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign finish = (state_q == ST_DONE);
  assign latch_pulse = finish && !op_erase_q;
  // Array is touched only when a validated operation finishes
  assign commit_pulse = finish && op_commit_q; // [R17]

  nvm_array u_array (
    .clk_i(REF_CLK_I),
    .addr_i(full_addr),
    .flash_i(control_q[nvm_ctrl_pkg::BIT_FLASH_SEL]), // [R13]
    .cfg_i(control_q[nvm_ctrl_pkg::BIT_CFG_SEL]),
    .wdata_i({data_hi_q, data_lo_q}),
    .latch_i(latch_pulse),
    .commit_i(commit_pulse),
    .erase_i(op_erase_q),
    .rdata_o(arr_rdata),
    .rvalid_o(arr_rvalid)
  );

  // ==========================================================================
  // Control register
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      control_q <= nvm_ctrl_pkg::CONTROL_RESET;
    end else begin
      if (wr_acc && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_CONTROL)) begin
        // Selects frozen while busy so a running operation keeps its target
        control_q[7:4] <= busy ? control_q[7:4] : wbyte[7:4];
        control_q[nvm_ctrl_pkg::BIT_PROG_EN] <= wbyte[nvm_ctrl_pkg::BIT_PROG_EN];
        control_q[nvm_ctrl_pkg::BIT_SEQ_ERR] <= wbyte[nvm_ctrl_pkg::BIT_SEQ_ERR];
      end
      if (start_ok) begin
        control_q[nvm_ctrl_pkg::BIT_PROG_START] <= 1'b1; // [R5]
      end
      if (start_req) begin
        control_q[nvm_ctrl_pkg::BIT_SEQ_ERR] <= 1'b1; // [R2]
      end
      // Read start only reads as one in its fetch cycle
      control_q[nvm_ctrl_pkg::BIT_READ_START] <= read_req; // [R6] [R7]
      if (finish) begin
        control_q[nvm_ctrl_pkg::BIT_PROG_START] <= 1'b0; // [R4]
        control_q[nvm_ctrl_pkg::BIT_SEQ_ERR] <= 1'b0; // [R2]
        if (op_erase_q) begin
          control_q[nvm_ctrl_pkg::BIT_ERASE_SEL] <= 1'b0; // [R16]
        end
      end
    end
  end

  // ==========================================================================
  // Address and data registers, frozen while busy: the finish edge uses them
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      addr_lo_q <= nvm_ctrl_pkg::ADDR_RESET;
    end else if (wr_acc && !busy && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_ADDR_LO)) begin
      addr_lo_q <= wbyte; // [R12]
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      addr_hi_q <= nvm_ctrl_pkg::ADDR_RESET[6:0];
    end else if (wr_acc && !busy && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_ADDR_HI)) begin
      addr_hi_q <= wbyte[6:0]; // [R10]
    end
  end

  // Data registers also load from the array on a read start
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      data_lo_q <= nvm_ctrl_pkg::DATA_RESET;
      data_hi_q <= nvm_ctrl_pkg::DATA_RESET[5:0];
    end else if (read_req && !start_req) begin
      // Unsupported config addresses yield zero from the array
      data_lo_q <= arr_rvalid ? arr_rdata[7:0] : 8'h00; // [R6] [R14]
      data_hi_q <= arr_rvalid ? arr_rdata[13:8] : 6'h00; // [R14]
    end else if (wr_acc && !busy) begin
      if (hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_DATA_LO)) data_lo_q <= wbyte; // [R12]
      if (hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_DATA_HI)) data_hi_q <= wbyte[5:0]; // [R11]
    end
  end

  // ==========================================================================
  // Interrupts: set wins over write-one-to-clear
  assign irq_event[nvm_ctrl_pkg::IRQ_DONE] = finish;
  assign irq_event[nvm_ctrl_pkg::IRQ_ABORT] = abort;
  assign irq_clear_wr = wr_acc && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_IRQ_STATUS);

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      irq_stat_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (irq_event[i]) begin
          irq_stat_q[i] <= 1'b1;
        end else if (irq_clear_wr && wbyte[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      irq_mask_q <= 2'h0;
    end else if (wr_acc && hit(AVS_ADDRESS_I, nvm_ctrl_pkg::OFS_IRQ_MASK)) begin
      irq_mask_q <= wbyte[1:0];
    end
  end

  // Registered so the pin cannot glitch; costs one cycle of lag
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign AVS_READDATA_O = rdata_q;
  assign AVS_WAITREQUEST_O = wait_q;
  assign IRQ_O = irq_q;
endmodule
`default_nettype wire

// *** rtl/nvm_ctrl_pkg.sv ***
// Package: register map, field positions, reset values and timing for the NVM controller
package nvm_ctrl_pkg;
  // ==========================================================================
  // Register offsets (word addresses, one word each)
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_UNLOCK = 4'h1;
  localparam logic [3:0] OFS_ADDR_LO = 4'h2;
  localparam logic [3:0] OFS_ADDR_HI = 4'h3;
  localparam logic [3:0] OFS_DATA_LO = 4'h4;
  localparam logic [3:0] OFS_DATA_HI = 4'h5;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
  // ==========================================================================
  // Control field positions
  localparam int BIT_FLASH_SEL = 7;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_ERASE_SEL = 4;
  localparam int BIT_SEQ_ERR = 3;
  localparam int BIT_PROG_EN = 2;
  localparam int BIT_PROG_START = 1;
  localparam int BIT_READ_START = 0;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  // ==========================================================================
  // Unlock pattern and reset values
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ADDR_HI_FILL = 8'h80;
  // ==========================================================================
  // Config space map
  localparam logic [14:0] CFG_USER_ID_FIRST = 15'h0000;
  localparam logic [14:0] CFG_USER_ID_LAST = 15'h0003;
  localparam logic [14:0] CFG_DEV_ID = 15'h0006;
  localparam logic [14:0] CFG_WORD_LAST = 15'h0008;
  // ==========================================================================
  // Self-timed operation duration
  localparam int PROG_TIME_US = 2000;
  localparam int CLK_MHZ = 25;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int LATCH_ROWS = 32;
endpackage

// *** rtl/nvm_unlock.sv ***
// Unlock pattern recogniser for the write-only unlock port
`timescale 1ns/100ps
`default_nettype none
module nvm_unlock (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  input wire logic consume_i,
  input wire logic other_wr_i,
  output logic armed_o
);
  logic first_q;
  logic armed_q;
  // Value is never stored: only the pattern progress is kept
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (consume_i) begin
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (wr_i) begin
      first_q <= (data_i == nvm_ctrl_pkg::UNLOCK_FIRST);
      armed_q <= first_q && (data_i == nvm_ctrl_pkg::UNLOCK_SECOND);
    end else if (other_wr_i) begin
      // Any other register write between the steps breaks the sequence
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end
  end
  assign armed_o = armed_q;
endmodule
`default_nettype wire

// *** rtl/nvm_array.sv ***
// Behavioural memory arrays: program flash, data EEPROM, config space, write latches
`timescale 1ns/100ps
`default_nettype none
module nvm_array #(
  parameter int FLASH_WORDS = 1024,
  parameter int EE_BYTES = 256,
  parameter int LATCHES = nvm_ctrl_pkg::LATCH_ROWS
) (
  input wire logic clk_i,
  input wire logic [14:0] addr_i,
  input wire logic flash_i,
  input wire logic cfg_i,
  input wire logic [13:0] wdata_i,
  input wire logic latch_i,
  input wire logic commit_i,
  input wire logic erase_i,
  output logic [13:0] rdata_o,
  output logic rvalid_o
);
  localparam int FA = $clog2(FLASH_WORDS);
  localparam int EA = $clog2(EE_BYTES);
  localparam int LA = $clog2(LATCHES);
  logic [13:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [13:0] cfg_mem [16];
  logic [13:0] latch_mem [LATCHES];
  logic [FA-1:0] fa;
  logic [EA-1:0] ea;
  logic [LA-1:0] la;
  logic [FA-1:0] row_base;
  logic [3:0] ca;
  logic user_id;

  function automatic logic cfg_readable(input logic [14:0] a);
    cfg_readable = (a <= nvm_ctrl_pkg::CFG_USER_ID_LAST) ||
      (a >= nvm_ctrl_pkg::CFG_DEV_ID && a <= nvm_ctrl_pkg::CFG_WORD_LAST);
  endfunction

  assign fa = addr_i[FA-1:0];
  assign ea = addr_i[EA-1:0];
  assign la = addr_i[LA-1:0];
  assign ca = addr_i[3:0];
  assign row_base = fa & ~FA'(LATCHES - 1);
  assign user_id = (addr_i <= nvm_ctrl_pkg::CFG_USER_ID_LAST);
  assign rvalid_o = cfg_i ? cfg_readable(addr_i) : 1'b1;

  always_comb begin
    if (cfg_i) begin
      rdata_o = cfg_readable(addr_i) ? cfg_mem[ca] : 14'h0000;
    end else if (flash_i) begin
      rdata_o = flash_mem[fa];
    end else begin
      rdata_o = {6'h00, ee_mem[ea]};
    end
  end

  // Data EEPROM: erase then write in one go; flash: latch, commit or row erase
  always_ff @(posedge clk_i) begin
    if (!flash_i && !cfg_i && commit_i) begin
      ee_mem[ea] <= wdata_i[7:0];
    end
    if (latch_i && (flash_i || cfg_i)) begin
      latch_mem[la] <= wdata_i;
    end
    if (commit_i && flash_i && !cfg_i) begin
      for (int i = 0; i < LATCHES; i++) begin
        // The word latched on this edge is not in latch_mem yet
        flash_mem[row_base | FA'(i)] <= erase_i ? 14'h3FFF :
          ((latch_i && LA'(i) == la) ? wdata_i : latch_mem[i]);
      end
    end
    if (commit_i && cfg_i && user_id) begin
      cfg_mem[ca] <= erase_i ? 14'h3FFF : (latch_i ? wdata_i : latch_mem[la]);
    end
  end
endmodule
`default_nettype wire

// *** verification/nvm_ctrl_props.sv ***
// Concurrent checks on the NVM controller register slave ports
`timescale 1ns/100ps
`default_nettype none
module nvm_ctrl_props (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic IRQ_O
);
  logic [7:0] mask_q;
  logic en_q;
  logic wr_ok;
  logic rd_ok;
  logic req;
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;
  assign req = AVS_READ_I || AVS_WRITE_I;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ==========================================================
  // Shadows of mask and enable, taken at the answer edge
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      mask_q <= 8'h00;
    end else if (wr_ok && AVS_ADDRESS_I == nvm_ctrl_pkg::OFS_IRQ_MASK) begin
      mask_q <= {6'h00, AVS_WRITEDATA_I[1:0]};
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      en_q <= 1'b0;
    end else if (wr_ok && AVS_ADDRESS_I == nvm_ctrl_pkg::OFS_CONTROL) begin
      en_q <= AVS_WRITEDATA_I[nvm_ctrl_pkg::BIT_PROG_EN];
    end
  end
  // ==========================================================
  // Properties
  property p_answer_next;
    req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
  endproperty
  property p_wait_one;
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  property p_idle_wait;
    !req |=> AVS_WAITREQUEST_O;
  endproperty
  property p_rd_hold;
    !req |=> $stable(AVS_READDATA_O);
  endproperty
  property p_addr_hi;
    rd_ok && AVS_ADDRESS_I == nvm_ctrl_pkg::OFS_ADDR_HI |-> AVS_READDATA_O[7];
  endproperty
  property p_data_hi;
    rd_ok && AVS_ADDRESS_I == nvm_ctrl_pkg::OFS_DATA_HI |-> AVS_READDATA_O[7:6] == 2'b00;
  endproperty
  property p_unlock;
    rd_ok && AVS_ADDRESS_I == nvm_ctrl_pkg::OFS_UNLOCK |-> AVS_READDATA_O == 32'h0;
  endproperty
  property p_upper;
    rd_ok |-> AVS_READDATA_O[31:8] == 24'h0;
  endproperty
  property p_en_block;
    rd_ok && AVS_ADDRESS_I == nvm_ctrl_pkg::OFS_CONTROL && !en_q |-> !AVS_READDATA_O[1];
  endproperty
  // Output lags status by a cycle, so allow the previous mask
  property p_irq_mask;
    IRQ_O |-> mask_q != 8'h00 || $past(mask_q) != 8'h00;
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("no answer after request");
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved when idle");
  a_addr_hi: assert property (p_addr_hi) else $error("addr high bit7 low");
  a_data_hi: assert property (p_data_hi) else $error("data high top bits set");
  a_unlock: assert property (p_unlock) else $error("unlock port readable");
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  a_en_block: assert property (p_en_block) else $error("start while disabled");
  a_irq_mask: assert property (p_irq_mask) else $error("irq with mask clear");
  c_start: cover property (wr_ok && AVS_ADDRESS_I == 4'h0 && AVS_WRITEDATA_I[1]);
  c_irq: cover property ($rose(IRQ_O));
  c_cfg: cover property (wr_ok && AVS_ADDRESS_I == 4'h0 && AVS_WRITEDATA_I[6]);
endmodule
bind nvm_ctrl nvm_ctrl_props props_i (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// *** verification/nvm_ctrl_bench.sv ***
// Register-level bench for the NVM controller
`timescale 1ns/100ps
`default_nettype none
module nvm_ctrl_bench;
  logic clk;
  logic rst_n;
  logic [3:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wait_r;
  logic irq;
  logic [31:0] v;
  int n_mismatch;
  int check_count;
  // Short op time keeps the run brief
  nvm_ctrl #(.PROG_CYCLES(12)) dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_r), .IRQ_O(irq)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic dir, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    rd <= !dir;
    wr <= dir;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_r !== 1'b0) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, v, e);
  endtask
  // Unlock with a chosen first key, start, then poll until idle
  task automatic run_op(input logic [7:0] ctl, input logic busy, input logic [7:0] key);
    int n;
    bus(1'b1, 4'h0, ctl);
    bus(1'b1, 4'h1, key);
    bus(1'b1, 4'h1, nvm_ctrl_pkg::UNLOCK_SECOND);
    bus(1'b1, 4'h0, ctl | 8'h02);
    bus(1'b0, 4'h0, 8'h00);
    chk("start", v[3:1], {1'b1, ctl[2], busy});
    bus(1'b1, 4'h0, ctl | 8'h08);
    bus(1'b0, 4'h0, 8'h00);
    chk("start_held", v[1], busy);
    n = 0;
    do begin
      bus(1'b0, 4'h0, 8'h00);
      n++;
    end while (v[1] !== 1'b0 && n < 40);
    if (v[1] !== 1'b0) begin
      n_mismatch++;
      tally_and_finish();
    end
    chk("finish", v[3:1], {!busy, ctl[2], 1'b0});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    adr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(4'h0, 32'h0, "ctl_rst");
    rdc(4'h3, 32'h80, "adr_hi_rst");
    bus(1'b1, 4'h3, 8'hFF);
    rdc(4'h3, 32'hFF, "adr_hi");
    bus(1'b1, 4'h2, 8'hA5);
    rdc(4'h2, 32'hA5, "adr_lo");
    bus(1'b1, 4'h5, 8'hFF);
    rdc(4'h5, 32'h3F, "dat_hi");
    bus(1'b1, 4'h4, 8'h5A);
    rdc(4'h4, 32'h5A, "dat_lo");
    bus(1'b1, 4'h1, 8'h55);
    rdc(4'h1, 32'h0, "unlock");
    rdc(4'hC, 32'h0, "unmapped");
    // EEPROM write with erase-select set still writes
    bus(1'b1, 4'h3, 8'h00);
    bus(1'b1, 4'h2, 8'h10);
    bus(1'b1, 4'h4, 8'h3C);
    bus(1'b1, 4'h7, 8'h03);
    run_op(8'h14, 1'b1, nvm_ctrl_pkg::UNLOCK_FIRST);
    rdc(4'h6, 32'h1, "irq_done");
    chk("irq_on", irq, 1'b1);
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b1, 4'h0, 8'h01);
    bus(1'b0, 4'h0, 8'h00);
    chk("rd_clear", v[0], 1'b0);
    rdc(4'h4, 32'h3C, "ee_data");
    bus(1'b1, 4'h6, 8'h01);
    rdc(4'h6, 32'h0, "irq_clr");
    chk("irq_off", irq, 1'b0);
    // Disabled and badly unlocked starts leave the array alone
    bus(1'b1, 4'h4, 8'hC3);
    run_op(8'h00, 1'b0, nvm_ctrl_pkg::UNLOCK_FIRST);
    rdc(4'h6, 32'h2, "irq_abort");
    chk("irq_abort_on", irq, 1'b1);
    bus(1'b1, 4'h7, 8'h00);
    // Interrupt pin follows the mask one registered cycle later
    repeat (2) @(posedge clk);
    chk("irq_masked", irq, 1'b0);
    bus(1'b1, 4'h6, 8'h02);
    run_op(8'h04, 1'b0, nvm_ctrl_pkg::UNLOCK_SECOND);
    bus(1'b1, 4'h0, 8'h01);
    rdc(4'h4, 32'h3C, "ee_kept");
    // Flash word write and read back
    bus(1'b1, 4'h2, 8'h05);
    bus(1'b1, 4'h5, 8'h2A);
    bus(1'b1, 4'h4, 8'h5B);
    run_op(8'h84, 1'b1, nvm_ctrl_pkg::UNLOCK_FIRST);
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b1, 4'h5, 8'h00);
    bus(1'b1, 4'h0, 8'h81);
    rdc(4'h5, 32'h2A, "fl_hi");
    rdc(4'h4, 32'h5B, "fl_lo");
    // Config read outside the map clears both data registers
    // A read start uses the selects already held, so select first
    bus(1'b1, 4'h2, 8'h04);
    bus(1'b1, 4'h0, 8'h40);
    bus(1'b1, 4'h0, 8'h41);
    rdc(4'h4, 32'h0, "cfg_lo");
    rdc(4'h5, 32'h0, "cfg_hi");
    tally_and_finish();
  end
endmodule
`default_nettype wire
